/* File: inc/pvt_pkg.sv */
// Shared constants and types for the panel video timing host controller.
// Assumes a 250 MHz system clock; registers sit on an AHB-Lite slave.
package pvt_pkg;
  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Reset sequence times, in their own units
  localparam int unsigned SUPPLY_TO_RESET_MS = 5;
  localparam int unsigned RESET_LOW_US = 10;
  localparam int unsigned RESET_TO_CMD_MS = 10;
  // Millisecond figures are worked in 64 bits; 5 ms in picoseconds overflows 32 bits
  localparam int unsigned SUPPLY_TO_RESET_CYC = 32'((64'(SUPPLY_TO_RESET_MS) * 64'd1000000000
    + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned RESET_LOW_CYC = (RESET_LOW_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int unsigned RESET_TO_CMD_CYC = 32'((64'(RESET_TO_CMD_MS) * 64'd1000000000
    + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Pixel format data type codes
  localparam logic [5:0] DT_RGB565 = 6'h0e;
  localparam logic [5:0] DT_RGB666 = 6'h1e;
  localparam logic [5:0] DT_RGB666_LOOSE = 6'h2e;
  localparam logic [5:0] DT_RGB888 = 6'h3e;
  // Unit intervals per pixel
  localparam logic [4:0] UI_RGB565 = 5'h10;
  localparam logic [4:0] UI_RGB666 = 5'h12;
  localparam logic [4:0] UI_RGB888 = 5'h18;
  // Lane rate ceilings in Mbps
  localparam logic [10:0] RATE_FAST_MBPS = 11'h3e8;
  localparam logic [10:0] RATE_SLOW_MBPS = 11'h29a;
  // Line and frame timing defaults
  localparam logic [11:0] LINE_ACTIVE = 12'h320;
  localparam logic [11:0] LINE_SYNC_DEF = 12'h014;
  localparam logic [11:0] LINE_BACK_DEF = 12'h014;
  localparam logic [11:0] LINE_FRONT_DEF = 12'h020;
  localparam logic [11:0] FRAME_ACTIVE = 12'h500;
  localparam logic [11:0] FRAME_SYNC_DEF = 12'h004;
  localparam logic [11:0] FRAME_BACK_DEF = 12'h006;
  localparam logic [11:0] FRAME_FRONT_DEF = 12'h008;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FORMAT = 8'h08;
  localparam logic [7:0] REG_LINE_SYNC = 8'h0c;
  localparam logic [7:0] REG_LINE_BACK = 8'h10;
  localparam logic [7:0] REG_LINE_FRONT = 8'h14;
  localparam logic [7:0] REG_FRAME_SYNC = 8'h18;
  localparam logic [7:0] REG_FRAME_BACK = 8'h1c;
  localparam logic [7:0] REG_FRAME_FRONT = 8'h20;
  localparam logic [7:0] REG_FRAME_COUNT = 8'h24;
  // Control bit positions
  localparam int unsigned CTRL_SUPPLY_ON = 0;
  localparam int unsigned CTRL_RESET_REQ = 1;
  localparam int unsigned CTRL_VIDEO_EN = 2;
  // Timing region of a line or a frame
  typedef enum logic [1:0] {PVT_SYNC, PVT_BACK, PVT_ACTIVE, PVT_FRONT} pvt_region_t;
  // Porch and sync widths of one axis
  typedef struct packed {
    logic [11:0] sync_w;
    logic [11:0] back_w;
    logic [11:0] front_w;
  } pvt_axis_t;
  // Video stream outputs
  typedef struct packed {
    logic line_sync;
    logic frame_sync_active;
    logic data_enable;
    logic [5:0] data_type;
  } pvt_video_t;
endpackage

/* File: rtl/pvt_axis_counter.sv */
// One axis of the timing generator: walks sync, back porch, active, front porch.
// Assumes widths are held stable by the caller while counting.
`timescale 1ns/1ps
module pvt_axis_counter #(
  parameter int unsigned WIDTH = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic step,
  input wire logic [WIDTH-1:0] active_w,
  input wire pvt_pkg::pvt_axis_t widths,
  // Status
  output pvt_pkg::pvt_region_t region,
  output logic wrap
);
  initial begin
    if (WIDTH < 12) $error("pvt_axis_counter: WIDTH too small");
  end
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] region_len;
  logic last;
  pvt_pkg::pvt_region_t next_region;

  // Length of the current region; zero widths count as one
  assign region_len = (region == pvt_pkg::PVT_SYNC) ? widths.sync_w :
                      (region == pvt_pkg::PVT_BACK) ? widths.back_w :
                      (region == pvt_pkg::PVT_ACTIVE) ? active_w : widths.front_w;
  assign last = (count + 1'b1 >= region_len);
  assign next_region = pvt_pkg::pvt_region_t'(region + 2'h1);
  assign wrap = step && last && (region == pvt_pkg::PVT_FRONT);

  // Region and position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      region <= pvt_pkg::PVT_SYNC;
      count <= '0;
    end else if (!run) begin
      region <= pvt_pkg::PVT_SYNC;
      count <= '0;
    end else if (step) begin
      count <= last ? '0 : count + 1'b1;
      if (last) region <= next_region;
    end
  end
endmodule

/* File: rtl/pvt_reset_seq.sv */
// Panel reset sequencer: supply delay, release, command hold-off; low pulse on request.
// Assumes supply_on follows the real supplies of the panel.
`timescale 1ns/1ps
module pvt_reset_seq #(
  parameter int unsigned SUPPLY_CYC = pvt_pkg::SUPPLY_TO_RESET_CYC,
  parameter int unsigned PULSE_CYC = pvt_pkg::RESET_LOW_CYC,
  parameter int unsigned CMD_CYC = pvt_pkg::RESET_TO_CMD_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic supply_on,
  input wire logic reset_req,
  // Panel side and status
  output logic panel_reset_n,
  output logic cmd_ready
);
  initial begin
    if (SUPPLY_CYC < 1 || PULSE_CYC < 1 || CMD_CYC < 1) $error("pvt_reset_seq: zero count");
    if (SUPPLY_CYC > 32'h01000000 || PULSE_CYC > 32'h01000000 || CMD_CYC > 32'h01000000)
      $error("pvt_reset_seq: count exceeds timer");
  end
  typedef enum logic [2:0] {RS_OFF, RS_SUPPLY, RS_PULSE, RS_WAIT, RS_READY} pvt_rs_t;
  pvt_rs_t state;
  logic [23:0] timer;
  logic timer_done;
  assign timer_done = (timer == 24'h000000);

  // Sequencer; reset held low while supplies off or pulse under way
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= RS_OFF;
      timer <= '0;
      panel_reset_n <= 1'b0;
      cmd_ready <= 1'b0;
    end else if (!supply_on) begin
      state <= RS_OFF;
      panel_reset_n <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      unique case (state)
        RS_OFF: begin
          state <= RS_SUPPLY;
          timer <= 24'(SUPPLY_CYC - 1);
        end
        RS_SUPPLY: begin
          if (timer_done) begin
            state <= RS_WAIT;
            panel_reset_n <= 1'b1;
            timer <= 24'(CMD_CYC - 1);
          end else timer <= timer - 1'b1;
        end
        RS_PULSE: begin
          if (timer_done) begin
            state <= RS_WAIT;
            panel_reset_n <= 1'b1;
            timer <= 24'(CMD_CYC - 1);
          end else timer <= timer - 1'b1;
        end
        RS_WAIT: begin
          if (reset_req) begin
            state <= RS_PULSE;
            panel_reset_n <= 1'b0;
            timer <= 24'(PULSE_CYC - 1);
          end else if (timer_done) begin
            state <= RS_READY;
            cmd_ready <= 1'b1;
          end else timer <= timer - 1'b1;
        end
        RS_READY: begin
          if (reset_req) begin
            state <= RS_PULSE;
            panel_reset_n <= 1'b0;
            cmd_ready <= 1'b0;
            timer <= 24'(PULSE_CYC - 1);
          end
        end
        default: state <= RS_OFF;
      endcase
    end
  end
endmodule

/* File: rtl/pvt_host.sv */
// Host controller for a DSI video panel: reset sequencing, video timing, format choice.
// Assumes an AHB-Lite master on hclk; pixel clock arrives from outside and is sampled.
`timescale 1ns/1ps
module pvt_host #(
  parameter int unsigned SUPPLY_CYC = pvt_pkg::SUPPLY_TO_RESET_CYC,
  parameter int unsigned PULSE_CYC = pvt_pkg::RESET_LOW_CYC,
  parameter int unsigned CMD_CYC = pvt_pkg::RESET_TO_CMD_CYC,
  parameter int unsigned LANES = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel pins
  input wire logic pixel_clk,
  input wire logic frame_tear_flag,
  output logic panel_reset_n,
  // Video stream to the link transmitter
  output pvt_pkg::pvt_video_t video,
  output logic cmd_ready
);
  initial begin
    if (LANES < 2 || LANES > 4) $error("pvt_host: LANES must be 2 to 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [2:0] ctrl;
  logic [1:0] format_sel;
  pvt_pkg::pvt_axis_t line_w;
  pvt_pkg::pvt_axis_t frame_w;
  logic [15:0] frame_count;
  logic tear_seen;

  // Address phase capture
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok;
  logic [7:0] byte_addr;
  assign byte_addr = haddr[7:0];
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= byte_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Format selection and lane ceiling
  logic [5:0] sel_type;
  logic [4:0] sel_ui;
  logic [10:0] sel_rate;
  assign sel_type = (format_sel == 2'h0) ? pvt_pkg::DT_RGB565 :
                    (format_sel == 2'h1) ? pvt_pkg::DT_RGB666 :
                    (format_sel == 2'h2) ? pvt_pkg::DT_RGB666_LOOSE :
                    pvt_pkg::DT_RGB888;
  assign sel_ui = (format_sel == 2'h0) ? pvt_pkg::UI_RGB565 :
                  (format_sel == 2'h1) ? pvt_pkg::UI_RGB666 :
                  pvt_pkg::UI_RGB888;
  assign sel_rate = (format_sel[1] || LANES == 2) ? pvt_pkg::RATE_FAST_MBPS :
                    pvt_pkg::RATE_SLOW_MBPS;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
      format_sel <= 2'h3;
      line_w <= '{pvt_pkg::LINE_SYNC_DEF, pvt_pkg::LINE_BACK_DEF, pvt_pkg::LINE_FRONT_DEF};
      frame_w <= '{pvt_pkg::FRAME_SYNC_DEF, pvt_pkg::FRAME_BACK_DEF,
                   pvt_pkg::FRAME_FRONT_DEF};
    end else if (wr_pend) begin
      unique case (wr_addr)
        pvt_pkg::REG_CTRL: ctrl <= hwdata[2:0];
        pvt_pkg::REG_FORMAT: format_sel <= hwdata[1:0];
        pvt_pkg::REG_LINE_SYNC: line_w.sync_w <= hwdata[11:0];
        pvt_pkg::REG_LINE_BACK: line_w.back_w <= hwdata[11:0];
        pvt_pkg::REG_LINE_FRONT: line_w.front_w <= hwdata[11:0];
        pvt_pkg::REG_FRAME_SYNC: frame_w.sync_w <= hwdata[11:0];
        pvt_pkg::REG_FRAME_BACK: frame_w.back_w <= hwdata[11:0];
        pvt_pkg::REG_FRAME_FRONT: frame_w.front_w <= hwdata[11:0];
        default: ;
      endcase
    end else if (ctrl[pvt_pkg::CTRL_RESET_REQ]) begin
      ctrl[pvt_pkg::CTRL_RESET_REQ] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: registered mux, answers in the cycle after the address phase
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  assign status_word = {sel_rate, sel_ui, 13'h0000, tear_seen, cmd_ready, panel_reset_n};
  assign rd_mux = (byte_addr == pvt_pkg::REG_CTRL) ? {29'h0, ctrl} :
                  (byte_addr == pvt_pkg::REG_STATUS) ? status_word :
                  (byte_addr == pvt_pkg::REG_FORMAT) ? {24'h0, sel_type, format_sel} :
                  (byte_addr == pvt_pkg::REG_LINE_SYNC) ? {20'h0, line_w.sync_w} :
                  (byte_addr == pvt_pkg::REG_LINE_BACK) ? {20'h0, line_w.back_w} :
                  (byte_addr == pvt_pkg::REG_LINE_FRONT) ? {20'h0, line_w.front_w} :
                  (byte_addr == pvt_pkg::REG_FRAME_SYNC) ? {20'h0, frame_w.sync_w} :
                  (byte_addr == pvt_pkg::REG_FRAME_BACK) ? {20'h0, frame_w.back_w} :
                  (byte_addr == pvt_pkg::REG_FRAME_FRONT) ? {20'h0, frame_w.front_w} :
                  (byte_addr == pvt_pkg::REG_FRAME_COUNT) ? {16'h0000, frame_count} :
                  32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  logic seq_reset_n;
  logic seq_ready;
  pvt_reset_seq #(
    .SUPPLY_CYC(SUPPLY_CYC),
    .PULSE_CYC(PULSE_CYC),
    .CMD_CYC(CMD_CYC)
  ) u_reset (
    .hclk(hclk),
    .hresetn(hresetn),
    .supply_on(ctrl[pvt_pkg::CTRL_SUPPLY_ON]),
    .reset_req(ctrl[pvt_pkg::CTRL_RESET_REQ]),
    .panel_reset_n(seq_reset_n),
    .cmd_ready(seq_ready)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      panel_reset_n <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      panel_reset_n <= seq_reset_n;
      cmd_ready <= seq_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock and tear flag synchronisers
  logic [1:0] pclk_sync;
  logic pclk_last;
  logic [1:0] tear_sync;
  logic pix_step;
  assign pix_step = pclk_sync[1] && !pclk_last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_sync <= '0;
      pclk_last <= 1'b0;
      tear_sync <= '0;
      tear_seen <= 1'b0;
    end else begin
      pclk_sync <= {pclk_sync[0], pixel_clk};
      pclk_last <= pclk_sync[1];
      tear_sync <= {tear_sync[0], frame_tear_flag};
      if (tear_sync[1]) tear_seen <= 1'b1;
      else if (wr_pend && wr_addr == pvt_pkg::REG_STATUS) tear_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line and frame counters
  logic run;
  logic line_wrap;
  logic frame_wrap;
  pvt_pkg::pvt_region_t line_region;
  pvt_pkg::pvt_region_t frame_region;
  assign run = ctrl[pvt_pkg::CTRL_VIDEO_EN] && seq_ready;

  pvt_axis_counter #(.WIDTH(12)) u_line (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .step(pix_step),
    .active_w(pvt_pkg::LINE_ACTIVE),
    .widths(line_w),
    .region(line_region),
    .wrap(line_wrap)
  );

  pvt_axis_counter #(.WIDTH(12)) u_frame (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .step(line_wrap),
    .active_w(pvt_pkg::FRAME_ACTIVE),
    .widths(frame_w),
    .region(frame_region),
    .wrap(frame_wrap)
  );

  // Video outputs and frame counter (frame rate check by software)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      video <= '0;
      frame_count <= '0;
    end else begin
      video.line_sync <= run && (line_region == pvt_pkg::PVT_SYNC);
      video.frame_sync_active <= run && (frame_region == pvt_pkg::PVT_SYNC);
      video.data_enable <= run && (line_region == pvt_pkg::PVT_ACTIVE)
                           && (frame_region == pvt_pkg::PVT_ACTIVE);
      video.data_type <= sel_type;
      if (frame_wrap) frame_count <= frame_count + 16'h0001;
    end
  end
endmodule

/* File: bench/pvt_panel_model.sv */
// Panel stand-in: answers tear requests and watches the incoming type code.
// Assumes the bench raises tear_req; a panel held in reset stays quiet.
`timescale 1ns/1ps
module pvt_panel_model (
  // Clock
  input wire logic hclk,
  // Host side
  input wire logic panel_reset_n,
  input wire pvt_pkg::pvt_video_t video,
  input wire logic tear_req,
  // Panel outputs
  output logic frame_tear_flag,
  output logic bad_type
);
  // Only the four pixel packet codes are accepted
  wire type_ok = video.data_type inside {6'h0e, 6'h1e, 6'h2e, 6'h3e};
  initial begin
    frame_tear_flag = 1'b0;
    bad_type = 1'b0;
  end
  // Tear pulse only while out of reset; low level resets the panel
  always @(posedge hclk) begin
    frame_tear_flag <= tear_req && panel_reset_n;
    if (video.data_enable && !type_ok) begin
      bad_type <= 1'b1;
    end
  end
endmodule

/* File: bench/pvt_host_checker.sv */
// Checker for the panel host: reset sequencing and video timing relations.
// Assumes it is bound into pvt_host and sees only its ports.
`timescale 1ns/1ps
module pvt_host_checker #(
  parameter int unsigned SUPPLY_CYC = 20,
  parameter int unsigned PULSE_CYC = 5,
  parameter int unsigned CMD_CYC = 30
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Panel and video
  input wire logic pixel_clk,
  input wire logic panel_reset_n,
  input wire pvt_pkg::pvt_video_t video,
  input wire logic cmd_ready
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  // Control write decode and pixel edge finder
  logic wr_ctrl;
  logic sup_on;
  logic [2:0] px_sync;
  int unsigned sup_cnt;
  int unsigned lo_cnt;
  int unsigned hi_cnt;
  int unsigned px_cnt;
  wire ctrl_hit = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
  wire px_rise = px_sync[1] && !px_sync[2];
  // Shadow of the supply bit as software last wrote it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl <= 1'b0;
      sup_on <= 1'b0;
      px_sync <= 3'h0;
    end else begin
      wr_ctrl <= ctrl_hit;
      sup_on <= wr_ctrl ? hwdata[0] : sup_on;
      px_sync <= {px_sync[1:0], pixel_clk};
    end
  end
  // Cycle counters for supply and reset levels; pixel clock rise counter while data enable is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_cnt <= 0;
      lo_cnt <= 0;
      hi_cnt <= 0;
      px_cnt <= 0;
    end else begin
      sup_cnt <= sup_on ? sup_cnt + 1 : 0;
      lo_cnt <= panel_reset_n ? 0 : lo_cnt + 1;
      hi_cnt <= panel_reset_n ? hi_cnt + 1 : 0;
      px_cnt <= video.data_enable ? px_cnt + (px_rise ? 1 : 0) : 0;
    end
  end
  ////////////////////////////////////////
  supply_wait_a: assert property ($rose(panel_reset_n) |-> sup_cnt >= SUPPLY_CYC)
    else $error("reset released too soon after supply on");
  reset_pulse_a: assert property ($rose(panel_reset_n) |-> lo_cnt >= PULSE_CYC)
    else $error("reset low pulse too short");
  cmd_holdoff_a: assert property ($rose(cmd_ready) |-> hi_cnt >= CMD_CYC)
    else $error("command ready too soon after reset release");
  cmd_drop_a: assert property ($fell(panel_reset_n) |-> ##[0:2] !cmd_ready)
    else $error("command ready kept during reset");
  supply_drop_a: assert property ($fell(sup_on) |-> ##[0:3] !panel_reset_n)
    else $error("reset not driven low on supply off");
  line_active_a: assert property ($fell(video.data_enable) |-> px_cnt inside {[799:801]})
    else $error("active line length wrong");
  sync_blank_a: assert property (video.line_sync |-> !video.data_enable)
    else $error("pixels during line sync");
  frame_blank_a: assert property (video.frame_sync_active |-> !video.data_enable)
    else $error("pixels during frame sync");
  type_code_a: assert property (video.data_enable |->
    video.data_type inside {6'h0e, 6'h1e, 6'h2e, 6'h3e})
    else $error("illegal data type code");
  // Main scenarios reached
  cover property ($rose(cmd_ready));
  cover property ($fell(video.data_enable));
  cover property ($rose(video.frame_sync_active));
endmodule
bind pvt_host pvt_host_checker #(.SUPPLY_CYC(SUPPLY_CYC), .PULSE_CYC(PULSE_CYC),
  .CMD_CYC(CMD_CYC)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .pixel_clk(pixel_clk), .panel_reset_n(panel_reset_n), .video(video),
  .cmd_ready(cmd_ready));

/* File: bench/tb.sv */
// Bench for the panel host: registers, reset sequence and video timing.
// Assumes shortened sequencer counts; pixel clock made here at 64 ns.
`timescale 1ns/1ps
module tb;
  localparam int SC = 20;
  localparam int PC = 5;
  localparam int CC = 30;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pixel_clk = 1'b0;
  logic tear_req = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, frame_tear_flag, panel_reset_n, cmd_ready, bad_type;
  pvt_pkg::pvt_video_t video;
  logic [31:0] rd;
  int num_errors = 0;
  int checks = 0;
  int n;
  logic [31:0] rv [10] = '{32'h0, 32'h7d180000, 32'hfb, 32'h14, 32'h14, 32'h20, 32'h4,
    32'h6, 32'h8, 32'h0};
  logic [5:0] dt [4] = '{6'h0e, 6'h1e, 6'h2e, 6'h3e};
  logic [4:0] ui [4] = '{5'h10, 5'h12, 5'h18, 5'h18};
  logic [10:0] rt [4] = '{11'h29a, 11'h29a, 11'h3e8, 11'h3e8};
  wire [4:0] sv = {cmd_ready, panel_reset_n, video.frame_sync_active, video.line_sync,
    video.data_enable};
  ////////////////////////////////////////
  // Clocks: pixel clock offset so its edges never meet hclk edges; slowed for run length
  always #2 hclk = ~hclk;
  initial begin
    #7;
    forever #32 pixel_clk = ~pixel_clk;
  end
  pvt_host #(.SUPPLY_CYC(SC), .PULSE_CYC(PC), .CMD_CYC(CC), .LANES(4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pixel_clk(pixel_clk),
    .frame_tear_flag(frame_tear_flag), .panel_reset_n(panel_reset_n), .video(video),
    .cmd_ready(cmd_ready));
  pvt_panel_model i_panel (.hclk(hclk), .panel_reset_n(panel_reset_n), .video(video),
    .tear_req(tear_req), .frame_tear_flag(frame_tear_flag), .bad_type(bad_type));
  ////////////////////////////////////////
  // One single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Cycles for which one watched output holds a level
  task automatic meas(input int s, input logic lv);
    n = 0;
    while (sv[s] === lv) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    final_report;
  end
  // Test sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 32'(4 * i), 32'h0);
      chk("reset value", rd, rv[i]);
    end
    bus(1'b0, 32'h24, 32'h0);
    chk("frame count", rd, rv[9]);
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, 32'h8, 32'(f));
      bus(1'b0, 32'h8, 32'h0);
      chk("format", rd, {24'h0, dt[f], 2'(f)});
      bus(1'b0, 32'h4, 32'h0);
      chk("ui and rate", rd[31:16], {rt[f], ui[f]});
    end
    bus(1'b1, 32'h28, 32'hffffffff);
    bus(1'b0, 32'h28, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("response", hresp, 32'h0);
    // Power up, then supply off and on again
    bus(1'b1, 32'h0, 32'h1);
    meas(3, 1'b0);
    chk("supply wait", 32'(n >= SC && n <= SC + 4), 32'h1);
    meas(4, 1'b0);
    chk("command wait", 32'(n >= CC && n <= CC + 4), 32'h1);
    bus(1'b0, 32'h4, 32'h0);
    chk("status", rd[2:0], 32'h3);
    bus(1'b1, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    chk("reset low", {cmd_ready, panel_reset_n}, 32'h0);
    bus(1'b1, 32'h0, 32'h1);
    meas(3, 1'b0);
    meas(4, 1'b0);
    // Reset pulse on request while running
    bus(1'b1, 32'h0, 32'h3);
    meas(3, 1'b1);
    meas(3, 1'b0);
    chk("pulse width", 32'(n >= PC && n <= PC + 3), 32'h1);
    chk("no command", cmd_ready, 32'h0);
    meas(4, 1'b0);
    chk("command wait", 32'(n >= CC), 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    chk("request cleared", rd, 32'h1);
    // Tear flag sticky bit
    tear_req <= 1'b1;
    @(posedge hclk);
    tear_req <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(1'b0, 32'h4, 32'h0);
    chk("tear seen", rd[2], 32'h1);
    bus(1'b1, 32'h4, 32'h0);
    bus(1'b0, 32'h4, 32'h0);
    chk("tear clear", rd[2], 32'h0);
    // Video with short porches: line is 809 pixels
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b1, 32'hc, 32'h2);
    bus(1'b1, 32'h10, 32'h3);
    bus(1'b1, 32'h14, 32'h4);
    bus(1'b1, 32'h18, 32'h1);
    bus(1'b1, 32'h1c, 32'h1);
    bus(1'b1, 32'h0, 32'h5);
    meas(2, 1'b0);
    meas(2, 1'b1);
    // First line starts at an arbitrary pixel phase, so up to one pixel is lost
    chk("frame sync", 32'(n > 808 * 16 && n <= 809 * 16), 32'h1);
    meas(0, 1'b0);
    chk("frame back", n, 809 * 16 + 80);
    chk("type", video.data_type, 32'h1e);
    meas(0, 1'b1);
    chk("active", n, 800 * 16);
    meas(1, 1'b0);
    chk("line front", n, 64);
    meas(1, 1'b1);
    chk("line sync", n, 32);
    meas(0, 1'b0);
    chk("line back", n, 48);
    chk("model type", bad_type, 32'h0);
    final_report;
  end
endmodule
